// file: hdl/acj_pkg.sv
// Package: codes, register map and carrier types of the accumulator executor
package acj_pkg;
   // ----------------------------------------------------------------
   // Instruction numbers and reply status codes
   // ----------------------------------------------------------------
   localparam logic [7:0] INS_INPUT_READ = 8'h0F;
   localparam logic [7:0] INS_ARITH = 8'h13;
   localparam logic [7:0] INS_COMPARE = 8'h14;
   localparam logic [7:0] INS_COND_JUMP = 8'h15;
   localparam logic [7:0] STAT_OK = 8'h64;
   localparam logic [7:0] STAT_BAD_INSTR = 8'h02;

   // ----------------------------------------------------------------
   // Arithmetic operation and jump condition type codes
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_ADD = 8'h00;
   localparam logic [7:0] OP_SUB = 8'h01;
   localparam logic [7:0] OP_MULTIPLY = 8'h02;
   localparam logic [7:0] OP_DIV = 8'h03;
   localparam logic [7:0] OP_REMAINDER = 8'h04;
   localparam logic [7:0] OP_AND = 8'h05;
   localparam logic [7:0] OP_OR = 8'h06;
   localparam logic [7:0] OP_XOR = 8'h07;
   localparam logic [7:0] OP_NOT = 8'h08;
   localparam logic [7:0] OP_LOAD = 8'h09;
   localparam logic [7:0] COND_ZERO = 8'h00;
   localparam logic [7:0] COND_NONZERO = 8'h01;
   localparam logic [7:0] COND_EQUAL = 8'h02;
   localparam logic [7:0] COND_NOT_EQUAL = 8'h03;
   localparam logic [7:0] COND_GREATER = 8'h04;
   localparam logic [7:0] COND_GREATER_EQUAL = 8'h05;
   localparam logic [7:0] COND_LOWER = 8'h06;
   localparam logic [7:0] COND_LOWER_EQUAL = 8'h07;
   localparam logic [7:0] COND_TIMEOUT_ERROR = 8'h08;
   localparam logic [7:0] COND_EXTERNAL_ALARM = 8'h09;
   localparam logic [7:0] COND_DEVIATION_ERROR = 8'h0A;
   localparam logic [7:0] COND_POSITION_ERROR = 8'h0B;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_ACCUM = 8'h08;
   localparam logic [7:0] REG_PC = 8'h0C;
   localparam logic [7:0] REG_CMD_HDR = 8'h10;
   localparam logic [7:0] REG_CMD_VAL = 8'h14;
   localparam logic [7:0] REG_CMD_CSUM = 8'h18;
   localparam logic [7:0] REG_REPLY_HDR = 8'h1C;
   localparam logic [7:0] REG_REPLY_VAL = 8'h20;
   localparam logic [7:0] REG_REPLY_CSUM = 8'h24;
   localparam logic [7:0] REG_PROG_ADDR = 8'h28;
   localparam logic [7:0] REG_PROG_HI = 8'h2C;
   localparam logic [7:0] REG_PROG_LO = 8'h30;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int CTRL_RUN_BIT = 0;
   localparam int STS_BUSY_BIT = 0;
   localparam int STS_REPLY_BIT = 1;
   localparam int STS_CSUM_BIT = 2;
   localparam int STS_LOST_BIT = 3;
   localparam int STS_ZERO_BIT = 4;
   localparam int STS_GREATER_BIT = 5;
   localparam int STS_LOWER_BIT = 6;
   localparam logic [31:0] ACC_RESET = 32'h0000_0000;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] bank;
      logic [7:0] kind;
      logic [7:0] instr;
      logic [31:0] value;
   } acj_instr_t;

   typedef struct packed {
      logic [7:0] host;
      logic [7:0] target;
      logic [7:0] status;
      logic [7:0] instr;
      logic [31:0] value;
      logic [7:0] csum;
   } acj_reply_t;

   typedef struct packed {
      logic lower;
      logic greater;
      logic zero;
   } acj_flags_t;

   typedef struct packed {
      logic position;
      logic deviation;
      logic alarm;
      logic timeout;
   } acj_err_t;

   typedef struct packed {
      logic [7:0] port;
      logic [7:0] bank;
   } acj_in_sel_t;

   localparam int INSTR_W = $bits(acj_instr_t);
endpackage : acj_pkg

// file: hdl/acj_prog_mem.sv
// Stored program memory with registered read data
`timescale 1ns/100ps
module acj_prog_mem #(
   parameter int DW = 56,
   parameter int AW = 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Write port
   input wire logic wr_en_i,
   input wire logic [AW-1:0] wr_addr_i,
   input wire logic [DW-1:0] wr_data_i,
   // Read port
   input wire logic rd_en_i,
   input wire logic [AW-1:0] rd_addr_i,
   output logic [DW-1:0] rd_data_o
);
   logic [DW-1:0] mem [0:(1<<AW)-1];
   logic [DW-1:0] next_rd_data;

   always_comb begin
      next_rd_data = rd_data_o;
      if (rd_en_i) begin
         next_rd_data = mem[rd_addr_i];
      end
   end

   always_ff @(posedge clk_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_data_o <= '0;
      end else begin
         rd_data_o <= next_rd_data;
      end
   end
endmodule : acj_prog_mem

// file: hdl/acj_core.sv
// Accumulator arithmetic, compare and conditional jump executor
//
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps
// How it works
// - Arithmetic applies the chosen operation to the accumulator with the 32-bit operand, writes back, ignores bank.
// - Arithmetic types 0 to 4 add, subtract, multiply, divide and take the remainder.
// - Types 5 to 7 are bitwise and, or, xor with the operand; type 8 inverts the accumulator alone.
// - Type 9 loads the operand into the accumulator.
// - In direct mode arithmetic replies with status 100 and echoes the operand.
// - Compare sets the zero, greater and lower flags from accumulator versus operand.
// - A conditional jump loads the program counter only when its condition holds, else goes on.
// - Jump types 0 to 7 test zero, nonzero, equal, not equal, greater, greater-equal, lower, lower-equal.
// - Jump types 8 to 11 test timeout, external alarm, deviation and position error flags.
// - A reply holds host, target, status, instruction, value most significant byte first, checksum; success is 64 hex.
// - An input read goes to the accumulator when stored, and only to the reply value when direct.
module acj_core #(
   parameter logic [7:0] HOST_ADDR = 8'h02,
   parameter logic [7:0] MODULE_ADDR = 8'h01,
   parameter int PC_W = 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Input read and error flags
   output acj_pkg::acj_in_sel_t in_sel_o,
   input wire logic [31:0] in_value_i,
   input wire acj_pkg::acj_err_t err_i
);
   import acj_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_LOAD, ST_EXEC} acj_state_t;

   acj_state_t state, next_state;
   acj_instr_t cur, next_cur;
   acj_reply_t reply, next_reply;
   acj_flags_t flags, next_flags;
   logic direct, next_direct;
   logic run, next_run;
   logic reply_valid, next_reply_valid;
   logic csum_err, next_csum_err;
   logic cmd_lost, next_cmd_lost;
   logic [31:0] acc, next_acc;
   logic [31:0] cmd_hdr, next_cmd_hdr;
   logic [31:0] cmd_val, next_cmd_val;
   logic [PC_W-1:0] pc, next_pc;
   logic [PC_W-1:0] prog_addr, next_prog_addr;
   logic [23:0] prog_hi, next_prog_hi;
   logic [31:0] next_dat;
   logic next_ack;
   logic bus_wr, bus_rd, mem_we, mem_re, cond_ok, csum_ok;
   logic [INSTR_W-1:0] mem_rd;
   logic [PC_W-1:0] jump_pc;
   logic [31:0] operand;

   assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
   assign bus_rd = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign operand = cur.value;
   assign jump_pc = cur.value[PC_W-1:0];
   assign in_sel_o = '{port: cur.kind, bank: cur.bank};

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] sel);
      for (int i = 0; i < 4; i++) begin
         merge[8*i +: 8] = sel[i] ? nw[8*i +: 8] : old[8*i +: 8];
      end
   endfunction : merge

   function automatic logic [7:0] byte_sum(input logic [31:0] w);
      byte_sum = w[7:0] + w[15:8] + w[23:16] + w[31:24];
   endfunction : byte_sum

   // Divide and remainder by zero leave the accumulator as it was
   function automatic logic [31:0] arith(input logic [7:0] op,
                                         input logic signed [31:0] a,
                                         input logic signed [31:0] b);
      logic signed [63:0] prod;
      prod = a * b;
      case (op)
         OP_ADD: arith = a + b;
         OP_SUB: arith = a - b;
         OP_MULTIPLY: arith = prod[31:0];
         OP_DIV: arith = (b == WORD_ZERO) ? a : a / b;
         OP_REMAINDER: arith = (b == WORD_ZERO) ? a : a % b;
         OP_AND: arith = a & b;
         OP_OR: arith = a | b;
         OP_XOR: arith = a ^ b;
         OP_NOT: arith = ~a;
         OP_LOAD: arith = b;
         default: arith = a;
      endcase
   endfunction : arith

   function automatic logic cond_hold(input logic [7:0] kind,
                                      input acj_flags_t f,
                                      input acj_err_t e);
      case (kind)
         COND_ZERO: cond_hold = f.zero;
         COND_NONZERO: cond_hold = !f.zero;
         COND_EQUAL: cond_hold = f.zero;
         COND_NOT_EQUAL: cond_hold = !f.zero;
         COND_GREATER: cond_hold = f.greater;
         COND_GREATER_EQUAL: cond_hold = !f.lower;
         COND_LOWER: cond_hold = f.lower;
         COND_LOWER_EQUAL: cond_hold = !f.greater;
         COND_TIMEOUT_ERROR: cond_hold = e.timeout;
         COND_EXTERNAL_ALARM: cond_hold = e.alarm;
         COND_DEVIATION_ERROR: cond_hold = e.deviation;
         COND_POSITION_ERROR: cond_hold = e.position;
         default: cond_hold = 1'b0;
      endcase
   endfunction : cond_hold

   assign cond_ok = cond_hold(cur.kind, flags, err_i);
   assign csum_ok = (byte_sum(cmd_hdr) + byte_sum(cmd_val))
                    == wb_dat_i[7:0];

   // ----------------------------------------------------------------
   // Program store
   // ----------------------------------------------------------------
   acj_prog_mem #(.DW(INSTR_W), .AW(PC_W)) u_prog_mem (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_en_i(mem_we),
      .wr_addr_i(prog_addr),
      .wr_data_i({prog_hi, wb_dat_i}),
      .rd_en_i(mem_re),
      .rd_addr_i(pc),
      .rd_data_o(mem_rd)
   );

   // ----------------------------------------------------------------
   // Executor and register file
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_cur = cur;
      next_reply = reply;
      next_flags = flags;
      next_direct = direct;
      next_run = run;
      next_reply_valid = reply_valid;
      next_csum_err = csum_err;
      next_cmd_lost = cmd_lost;
      next_acc = acc;
      next_cmd_hdr = cmd_hdr;
      next_cmd_val = cmd_val;
      next_pc = pc;
      next_prog_addr = prog_addr;
      next_prog_hi = prog_hi;
      mem_we = 1'b0;
      mem_re = 1'b0;
      if (bus_wr) begin
         case (wb_adr_i)
            REG_CTRL: begin
               if (wb_sel_i[0]) begin
                  next_run = wb_dat_i[CTRL_RUN_BIT];
               end
            end
            REG_STATUS: begin
               if (wb_sel_i[0] && wb_dat_i[STS_REPLY_BIT]) begin
                  next_reply_valid = 1'b0;
               end
               if (wb_sel_i[0] && wb_dat_i[STS_CSUM_BIT]) begin
                  next_csum_err = 1'b0;
               end
               if (wb_sel_i[0] && wb_dat_i[STS_LOST_BIT]) begin
                  next_cmd_lost = 1'b0;
               end
            end
            REG_ACCUM: begin
               if (state == ST_IDLE && !run) begin
                  next_acc = merge(acc, wb_dat_i, wb_sel_i);
               end
            end
            REG_PC: begin
               if (state == ST_IDLE && !run) begin
                  next_pc = wb_dat_i[PC_W-1:0];
               end
            end
            REG_CMD_HDR: next_cmd_hdr = merge(cmd_hdr, wb_dat_i, wb_sel_i);
            REG_CMD_VAL: next_cmd_val = merge(cmd_val, wb_dat_i, wb_sel_i);
            REG_CMD_CSUM: begin
               if (!csum_ok) begin
                  next_csum_err = 1'b1;
               end else if (state != ST_IDLE || run) begin
                  next_cmd_lost = 1'b1;
               end else begin
                  next_cur = acj_instr_t'({cmd_hdr[31:8], cmd_val});
                  next_direct = 1'b1;
                  next_state = ST_EXEC;
               end
            end
            REG_PROG_ADDR: next_prog_addr = wb_dat_i[PC_W-1:0];
            REG_PROG_HI: next_prog_hi = wb_dat_i[23:0];
            REG_PROG_LO: begin
               mem_we = 1'b1;
               next_prog_addr = prog_addr + 1'b1;
            end
            default: begin
            end
         endcase
      end
      case (state)
         ST_IDLE: begin
            if (run && next_state == ST_IDLE) begin
               next_state = ST_FETCH;
            end
         end
         ST_FETCH: begin
            mem_re = 1'b1;
            next_state = ST_LOAD;
         end
         ST_LOAD: begin
            next_cur = acj_instr_t'(mem_rd);
            next_direct = 1'b0;
            next_state = ST_EXEC;
         end
         ST_EXEC: begin
            next_reply.host = HOST_ADDR;
            next_reply.target = MODULE_ADDR;
            next_reply.instr = cur.instr;
            next_reply.status = STAT_OK;
            next_reply.value = operand;
            next_pc = pc + 1'b1;
            case (cur.instr)
               INS_ARITH: begin
                  next_acc = arith(cur.kind, acc, operand);
               end
               INS_COMPARE: begin
                  next_flags.zero = (acc == operand);
                  next_flags.greater = $signed(acc) > $signed(operand);
                  next_flags.lower = $signed(acc) < $signed(operand);
               end
               INS_COND_JUMP: begin
                  // Direct jumps still move the counter when the condition holds
                  if (cond_ok) begin
                     next_pc = jump_pc;
                  end
               end
               INS_INPUT_READ: begin
                  next_reply.value = in_value_i;
                  if (!direct) begin
                     next_acc = in_value_i;
                  end
               end
               default: begin
                  next_reply.status = STAT_BAD_INSTR;
                  next_reply.value = WORD_ZERO;
               end
            endcase
            // Direct commands never advance the counter unless jumping
            if (direct && !(cur.instr == INS_COND_JUMP && cond_ok)) begin
               next_pc = pc;
            end
            next_reply.csum = byte_sum(next_reply[71:40])
                              + byte_sum(next_reply.value);
            if (direct) begin
               next_reply_valid = 1'b1;
               next_state = ST_IDLE;
            end else begin
               next_reply = reply;
               next_state = run ? ST_FETCH : ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
         cur <= '0;
         reply <= '0;
         flags <= '0;
         direct <= 1'b0;
         run <= 1'b0;
         reply_valid <= 1'b0;
         csum_err <= 1'b0;
         cmd_lost <= 1'b0;
         acc <= ACC_RESET;
         cmd_hdr <= WORD_ZERO;
         cmd_val <= WORD_ZERO;
         pc <= '0;
         prog_addr <= '0;
         prog_hi <= '0;
      end else begin
         state <= next_state;
         cur <= next_cur;
         reply <= next_reply;
         flags <= next_flags;
         direct <= next_direct;
         run <= next_run;
         reply_valid <= next_reply_valid;
         csum_err <= next_csum_err;
         cmd_lost <= next_cmd_lost;
         acc <= next_acc;
         cmd_hdr <= next_cmd_hdr;
         cmd_val <= next_cmd_val;
         pc <= next_pc;
         prog_addr <= next_prog_addr;
         prog_hi <= next_prog_hi;
      end
   end

   // ----------------------------------------------------------------
   // Bus answer
   // ----------------------------------------------------------------
   always_comb begin
      next_ack = bus_rd;
      next_dat = wb_dat_o;
      if (bus_rd) begin
         next_dat = WORD_ZERO;
         case (wb_adr_i)
            REG_CTRL: next_dat[CTRL_RUN_BIT] = run;
            REG_STATUS: begin
               next_dat[STS_BUSY_BIT] = run || state != ST_IDLE;
               next_dat[STS_REPLY_BIT] = reply_valid;
               next_dat[STS_CSUM_BIT] = csum_err;
               next_dat[STS_LOST_BIT] = cmd_lost;
               next_dat[STS_ZERO_BIT] = flags.zero;
               next_dat[STS_GREATER_BIT] = flags.greater;
               next_dat[STS_LOWER_BIT] = flags.lower;
            end
            REG_ACCUM: next_dat = acc;
            REG_PC: next_dat[PC_W-1:0] = pc;
            REG_CMD_HDR: next_dat = cmd_hdr;
            REG_CMD_VAL: next_dat = cmd_val;
            REG_REPLY_HDR: next_dat = {reply.instr, reply.status,
                                       reply.target, reply.host};
            REG_REPLY_VAL: next_dat = reply.value;
            REG_REPLY_CSUM: next_dat[7:0] = reply.csum;
            REG_PROG_ADDR: next_dat[PC_W-1:0] = prog_addr;
            REG_PROG_HI: next_dat[23:0] = prog_hi;
            default: next_dat = WORD_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= WORD_ZERO;
      end else begin
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_exec(logic [7:0] ins);
      state == ST_EXEC && cur.instr == ins;
   endsequence
   sequence s_arith(logic [7:0] op);
      s_exec(INS_ARITH) and (cur.kind == op);
   endsequence
   sequence s_stored_jump;
      s_exec(INS_COND_JUMP) and (!direct);
   endsequence

   AST_ARITH_ADD: assert property (s_arith(OP_ADD) |=>
      acc == $past(acc) + $past(operand))
      else $error("add result wrong");
   AST_ARITH_XOR: assert property (s_arith(OP_XOR) |=>
      acc == ($past(acc) ^ $past(operand)))
      else $error("xor result wrong");
   AST_ARITH_NOT: assert property (s_arith(OP_NOT) |=>
      acc == ~$past(acc))
      else $error("invert result wrong");
   AST_ARITH_LOAD: assert property (s_arith(OP_LOAD) |=>
      acc == $past(operand))
      else $error("load result wrong");
   AST_COMPARE: assert property (s_exec(INS_COMPARE) |=>
      flags.greater == ($signed($past(acc)) > $signed($past(operand)))
      && flags.zero == ($past(acc) == $past(operand)))
      else $error("compare flags wrong");
   AST_JUMP_TAKEN: assert property (s_stored_jump ##0 cond_ok |=>
      pc == $past(jump_pc))
      else $error("jump not taken");
   AST_JUMP_SKIP: assert property (s_stored_jump ##0 !cond_ok |=>
      pc == $past(pc) + 1'b1)
      else $error("jump taken wrongly");
   AST_JUMP_TIMEOUT: assert property (s_stored_jump
      ##0 (cur.kind == COND_TIMEOUT_ERROR && err_i.timeout)
      |=> pc == $past(jump_pc))
      else $error("error jump missed");
   AST_DIRECT_REPLY: assert property (s_exec(INS_ARITH) ##0 direct
      |=> reply_valid && reply.status == STAT_OK
      && reply.value == $past(operand) && state == ST_IDLE)
      else $error("direct reply wrong");
   AST_REPLY_CSUM: assert property ($rose(reply_valid) |->
      reply.csum == byte_sum({reply.host, reply.target, reply.status,
      reply.instr}) + byte_sum(reply.value))
      else $error("reply checksum wrong");
   AST_BAD_CSUM: assert property (bus_wr && wb_adr_i == REG_CMD_CSUM
      && !csum_ok |=> csum_err && state != ST_EXEC)
      else $error("bad command not refused");
   AST_INPUT_DIRECT: assert property (s_exec(INS_INPUT_READ)
      ##0 direct |=> acc == $past(acc) && reply.value == $past(in_value_i))
      else $error("direct input read wrong");
   AST_WB_ACK: assert property (bus_rd |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus ack timing wrong");
endmodule : acj_core

// file: sim/acj_host.sv
// Host model: Wishbone master that sends command frames
`timescale 1ns/100ps
module acj_host (
   // Bus towards the executor
   input wire logic clk_i,
   input wire logic ack_i,
   input wire logic [31:0] dat_i,
   output logic cyc_o,
   output logic we_o,
   output logic [7:0] adr_o,
   output logic [31:0] dat_o
);
   import acj_pkg::*;
   logic [31:0] rd;
   initial begin
      cyc_o = 1'b0;
      we_o = 1'b0;
      adr_o = 8'h00;
      dat_o = 32'h0;
   end
   // Held until ack is seen; released data is inverted, not left stale
   task automatic acc(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge clk_i);
      cyc_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      dat_o <= d;
      do @(posedge clk_i); while (ack_i !== 1'b1);
      rd = dat_i;
      cyc_o <= 1'b0;
      dat_o <= ~d;
   endtask : acc
   // Compare and jump travel only inside a stored program
   task automatic put(input logic [7:0] a, ins, k, input logic [31:0] v);
      acc(1'b1, REG_PROG_ADDR, {24'h0, a});
      acc(1'b1, REG_PROG_HI, {16'h0, k, ins});
      acc(1'b1, REG_PROG_LO, v);
   endtask : put
   // Direct frame; polls for the reply unless the checksum is spoilt
   task automatic cmd(input logic [7:0] ins, k, input logic [31:0] v,
      input logic [7:0] bad);
      logic [7:0] s;
      s = 8'h01 + ins + k + v[31:24] + v[23:16] + v[15:8] + v[7:0];
      acc(1'b1, REG_CMD_HDR, {8'h00, k, ins, 8'h01});
      acc(1'b1, REG_CMD_VAL, v);
      acc(1'b1, REG_CMD_CSUM, {24'h0, s + bad});
      if (bad == 8'h00) begin
         do acc(1'b0, REG_STATUS, 32'h0); while (rd[1] !== 1'b1);
         acc(1'b1, REG_STATUS, 32'h2);
      end
   endtask : cmd
endmodule : acj_host

// file: sim/tb_top.sv
// Testbench of the accumulator executor
`timescale 1ns/100ps
module tb_top;
   import acj_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc, we, ack;
   logic [7:0] adr;
   logic [31:0] wdat, rdat;
   acj_err_t err = '0;
   acj_in_sel_t sel;
   int miscompares = 0;
   int checks_done = 0;
   always #20 clk_i = ~clk_i;
   acj_host HOST (.clk_i, .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
      .we_o(we), .adr_o(adr), .dat_o(wdat));
   acj_core DUT (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .in_sel_o(sel),
      .in_value_i(32'h0000012E), .err_i(err));
   task automatic chk(input logic [31:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic test_done;
      $display("checks %0d bad %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : test_done
   task automatic t_ar;
      logic [31:0] e [10];
      e = '{32'hFFFFFFFC, 32'hFFFFFFF6, 32'hFFFFFFEB, 32'hFFFFFFFE,
         32'hFFFFFFFF, 32'h1, 32'hFFFFFFFB, 32'hFFFFFFFA, 32'h6, 32'h3};
      for (int i = 0; i < 10; i++) begin
         HOST.acc(1'b1, REG_ACCUM, 32'hFFFFFFF9);
         HOST.cmd(INS_ARITH, 8'(i), 32'h3, 8'h00);
         HOST.acc(1'b0, REG_ACCUM, 32'h0);
         chk(HOST.rd, e[i]);
      end
      HOST.acc(1'b0, REG_REPLY_HDR, 32'h0);
      chk(HOST.rd, {INS_ARITH, STAT_OK, 8'h01, 8'h02});
      HOST.acc(1'b0, REG_REPLY_VAL, 32'h0);
      chk(HOST.rd, 32'h3);
      HOST.acc(1'b0, REG_REPLY_CSUM, 32'h0);
      chk(HOST.rd & 32'hFF, 32'h7D);
      HOST.cmd(INS_INPUT_READ, 8'h09, 32'h0, 8'h00);
      HOST.acc(1'b0, REG_REPLY_VAL, 32'h0);
      chk(HOST.rd, 32'h12E);
      HOST.acc(1'b0, REG_ACCUM, 32'h0);
      chk(HOST.rd, 32'h3);
      chk({16'h0, sel}, 32'h0900);
      $display("arith end");
   endtask : t_ar
   task automatic jmp(input logic [31:0] op, input int c, input logic t);
      HOST.put(8'h00, INS_COMPARE, 8'h00, op);
      HOST.put(8'h01, INS_COND_JUMP, 8'(c), 32'h3);
      HOST.acc(1'b1, REG_ACCUM, 32'h5);
      HOST.acc(1'b1, REG_PC, 32'h0);
      HOST.acc(1'b1, REG_CTRL, 32'h1);
      repeat (24) @(posedge clk_i);
      HOST.acc(1'b1, REG_CTRL, 32'h0);
      do HOST.acc(1'b0, REG_STATUS, 32'h0); while (HOST.rd[0] !== 1'b0);
      HOST.acc(1'b0, REG_ACCUM, 32'h0);
      chk(HOST.rd, t ? 32'h5 : 32'h12E);
   endtask : jmp
   task automatic t_jc;
      logic [31:0] ops [3];
      logic z, g, l;
      logic [7:0] m;
      ops = '{32'h5, 32'h9, 32'hFFFFFFFF};
      // Not taken falls into an input read; both paths end in a loop
      HOST.put(8'h02, INS_INPUT_READ, 8'h00, 32'h0);
      HOST.put(8'h03, INS_COND_JUMP, COND_ZERO, 32'h3);
      HOST.put(8'h04, INS_COND_JUMP, COND_NONZERO, 32'h3);
      foreach (ops[i]) begin
         z = ops[i] == 32'h5;
         g = 32'sh5 > $signed(ops[i]);
         l = 32'sh5 < $signed(ops[i]);
         m = {!g, l, !l, g, !z, z, !z, z};
         for (int c = 0; c < 8; c++) jmp(ops[i], c, m[c]);
      end
      for (int j = 0; j < 4; j++) begin
         err <= acj_err_t'(~(4'h1 << j));
         jmp(32'h0, 8 + j, 1'b0);
         err <= acj_err_t'(4'h1 << j);
         jmp(32'h0, 8 + j, 1'b1);
      end
      $display("jump end");
   endtask : t_jc
   task automatic t_bad;
      HOST.cmd(INS_ARITH, OP_LOAD, 32'h77, 8'h01);
      HOST.acc(1'b0, REG_STATUS, 32'h0);
      chk(HOST.rd & 32'h6, 32'h4);
      HOST.acc(1'b0, REG_ACCUM, 32'h0);
      chk(HOST.rd, 32'h5);
      $display("checksum end");
   endtask : t_bad
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_ar();
      t_jc();
      t_bad();
      test_done();
   end
   // About 2200 cycles expected; the 30000-cycle limit, over ten times that, is a hang
   initial begin
      repeat (30000) @(posedge clk_i);
      miscompares++;
      test_done();
   end
endmodule : tb_top
